// ==== hdl/iswfl_pkg.sv ====
// package: register map, field positions and reset values of the switch fault latch block
package iswfl_pkg;
  // ****************************************
  // geometry
  // ****************************************
  localparam int NUM_CH = 4;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SWITCH_ENABLE_BITS = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_INT_STAT = 8'h0C;
  localparam logic [7:0] ADDR_INT_MASK = 8'h10;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_SERIAL_BIT = 0;
  localparam int STAT_LOAD_LSB = 0;
  localparam int STAT_PRESENT_BIT = 4;
  localparam int STAT_LATCHED_BIT = 5;
  localparam int STAT_COMM_LAT_BIT = 6;
  localparam int STAT_LOGIC_OK_BIT = 7;
  localparam int STAT_SWITCH_OK_BIT = 8;
  localparam int STAT_FLT_PIN_BIT = 9;
  localparam int STAT_IND_PIN_LSB = 10;
  localparam int INT_FAULT_RISE_BIT = 0;
  localparam int INT_LATCH_FREE_BIT = 1;
  localparam int INT_OT_BLOCK_BIT = 2;
  localparam int INT_WIDTH = 3;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [3:0] SWITCH_ENABLE_BITS_RESET = 4'h0;
  localparam logic [2:0] INT_RESET = 3'h0;
endpackage : iswfl_pkg

// ==== hdl/iswfl_fault.sv ====
// fault memory: previous fault state, remembered communication error and fault indicator drive
`timescale 1ns/100ps
`default_nettype none
module iswfl_fault
  import iswfl_pkg::*;
(
  input wire logic clk_sys_in, // system clock
  input wire logic rst_b_in, // async reset, active low
  input wire logic logic_ok_in, // logic supply above threshold
  input wire logic present_in, // present fault state detected
  input wire logic comm_err_in, // communication error reported
  input wire logic clear_in, // fault clear input level
  output logic latched_out, // remembered previous fault
  output logic comm_lat_out, // remembered communication error
  output logic flt_on_out // fault indicator asserted
);
  logic latched_ff, nxt_latched;
  logic comm_lat_ff, nxt_comm_lat;
  logic flt_ff, nxt_flt;
  logic release_w;

  // ****************************************
  // latch next state
  // ****************************************
  // a detected fault always wins over the clear, so no event slips through
  always_comb begin
    release_w = !present_in && clear_in;
    nxt_latched = present_in || (latched_ff && !release_w);
    nxt_comm_lat = comm_err_in || (comm_lat_ff && !release_w);
    // indicator released while unpowered: level is undefined there anyway
    nxt_flt = logic_ok_in && nxt_latched;
  end

  // registers only
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      latched_ff <= 1'b0;
      comm_lat_ff <= 1'b0;
      flt_ff <= 1'b0;
    end else begin
      latched_ff <= nxt_latched;
      comm_lat_ff <= nxt_comm_lat;
      flt_ff <= nxt_flt;
    end
  end

  assign latched_out = latched_ff;
  assign comm_lat_out = comm_lat_ff;
  assign flt_on_out = flt_ff;

  a_latch_holds: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (logic_ok_in && latched_ff && !clear_in) |=> flt_ff)
    else $error("fault indicator dropped while fault still remembered");
endmodule : iswfl_fault
`default_nettype wire

// ==== hdl/iswfl_chan.sv ====
// one switch channel: load output state with over-temperature constraint handling
`timescale 1ns/100ps
`default_nettype none
module iswfl_chan
  import iswfl_pkg::*;
(
  input wire logic clk_sys_in, // system clock
  input wire logic rst_b_in, // async reset, active low
  input wire logic req_in, // enable source and output gate both high
  input wire logic block_in, // supply or shutdown fault present, or communication error remembered
  input wire logic overtemp_in, // over-temperature constraint fault
  output logic on_out, // load output on
  output logic ot_block_out // turn-on refused by over-temperature
);
  logic on_ff, nxt_on;

  // ****************************************
  // channel next state
  // ****************************************
  // over-temperature keeps a running load on, but refuses a fresh turn-on
  always_comb begin
    ot_block_out = req_in && !block_in && overtemp_in && !on_ff;
    nxt_on = req_in && !block_in && (on_ff || !overtemp_in);
  end

  // registers only
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      on_ff <= 1'b0;
    end else begin
      on_ff <= nxt_on;
    end
  end

  assign on_out = on_ff;

  a_ot_no_start: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (!on_ff && overtemp_in) |=> !on_ff)
    else $error("channel turned on during over-temperature");
endmodule : iswfl_chan
`default_nettype wire

// ==== hdl/iswfl_top.sv ====
// top of the switch fault latch block: wishbone registers, fault logic, channels, interrupt
//
// Function
// - each output depends on present fault, remembered fault and current inputs
// - logic supply down: all loads and status indicators off
// - switch supply down is a fault: indicator on, all outputs off
// - remembered fault holds indicator until fault gone and clear input high
// - over-temperature arising while a channel is on does not stop it
// - over-temperature blocks a channel that is off from turning on
// - over-voltage leaves channel switching unchanged
// - remembered, still reported communication error keeps channels off
// - fault and status indicators are active-low open-drain pins
// - serial mode: switch enable bit n drives channel n
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module iswfl_top
  import iswfl_pkg::*;
(
  input wire logic clk_sys_in, // 125 MHz system clock
  input wire logic rst_b_in, // async reset, active low
  input wire logic wb_cyc_in, // wishbone cycle
  input wire logic wb_stb_in, // wishbone strobe
  input wire logic wb_we_in, // wishbone write enable
  input wire logic [7:0] wb_adr_in, // wishbone byte address
  input wire logic [3:0] wb_sel_in, // wishbone byte selects
  input wire logic [31:0] wb_dat_in, // wishbone write data
  output logic [31:0] wb_dat_out, // wishbone read data
  output logic wb_ack_out, // wishbone acknowledge
  output logic irq_out, // level interrupt, active high
  input wire logic [NUM_CH-1:0] channel_input_in, // channel enable pins
  input wire logic output_gate_in, // global output gate
  input wire logic fault_clear_input_in, // fault clear pin
  input wire logic logic_supply_ok_in, // logic supply powered
  input wire logic switch_supply_ok_in, // switch supply powered
  input wire logic [NUM_CH-1:0] overtemp_fault_in, // over-temperature constraint
  input wire logic overvoltage_fault_in, // over-voltage constraint
  input wire logic comm_error_fault_in, // communication error shutdown
  input wire logic shutdown_fault_in, // any other shutdown fault
  output logic [NUM_CH-1:0] load_output_out, // load outputs on
  input wire logic [NUM_CH-1:0] channel_status_indicator_n_in, // status pin level
  output logic [NUM_CH-1:0] channel_status_indicator_n_out, // status pin drive value
  output logic [NUM_CH-1:0] channel_status_indicator_n_oe, // status pin pulled low
  input wire logic fault_indicator_n_in, // fault pin level
  output logic fault_indicator_n_out, // fault pin drive value
  output logic fault_indicator_n_oe // fault pin pulled low
);
  // ****************************************
  // declarations
  // ****************************************
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic serial_ff, nxt_serial;
  logic [NUM_CH-1:0] switch_enable_bits_ff, nxt_switch_enable_bits;
  logic [INT_WIDTH-1:0] int_stat_ff, nxt_int_stat;
  logic [INT_WIDTH-1:0] int_mask_ff, nxt_int_mask;
  logic pres_d_ff, nxt_pres_d;
  logic latched_d_ff, nxt_latched_d;
  logic req_w, wr_w;
  logic [31:0] wmask_w;
  logic [31:0] wm_ctrl_w, wm_switch_enable_bits_w, wm_int_mask_w;
  logic [31:0] status_w;
  logic [INT_WIDTH-1:0] event_w;
  logic present_w, block_w, latched_w, comm_lat_w, flt_on_w;
  logic [NUM_CH-1:0] src_w, chan_req_w, on_w, ot_block_w;

  // byte selects widened to a bit mask
  function automatic logic [31:0] sel_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    return m;
  endfunction : sel_mask

  // merge write data into a register under the byte selects
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [31:0] m);
    return (old & ~m) | (dat & m);
  endfunction : merge

  // ****************************************
  // fault state
  // ****************************************
  // every fault counts as present, constraint ones included
  always_comb begin
    present_w = !switch_supply_ok_in || shutdown_fault_in || comm_error_fault_in
                || overvoltage_fault_in || (|overtemp_fault_in);
    // over-voltage is left out on purpose: outputs run normally under it
    block_w = !logic_supply_ok_in || !switch_supply_ok_in || shutdown_fault_in
              || comm_error_fault_in || comm_lat_w;
  end

  iswfl_fault u_fault (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .logic_ok_in(logic_supply_ok_in),
    .present_in(present_w),
    .comm_err_in(comm_error_fault_in),
    .clear_in(fault_clear_input_in),
    .latched_out(latched_w),
    .comm_lat_out(comm_lat_w),
    .flt_on_out(flt_on_w)
  );

  // ****************************************
  // channels
  // ****************************************
  // the remembered fault alone does not gate the channels, only the indicator
  always_comb begin
    src_w = serial_ff ? switch_enable_bits_ff : channel_input_in;
    chan_req_w = src_w & {NUM_CH{output_gate_in}};
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
    iswfl_chan u_chan (
      .clk_sys_in(clk_sys_in),
      .rst_b_in(rst_b_in),
      .req_in(chan_req_w[g]),
      .block_in(block_w),
      .overtemp_in(overtemp_fault_in[g]),
      .on_out(on_w[g]),
      .ot_block_out(ot_block_w[g])
    );
  end

  // ****************************************
  // pins
  // ****************************************
  // open-drain: value is always low, the enable decides whether it pulls
  assign load_output_out = on_w;
  assign channel_status_indicator_n_out = {NUM_CH{1'b0}};
  assign channel_status_indicator_n_oe = on_w;
  assign fault_indicator_n_out = 1'b0;
  assign fault_indicator_n_oe = flt_on_w;

  // ****************************************
  // wishbone slave
  // ****************************************
  // one wait state: ack one edge after the request, read data registered with it
  always_comb begin
    req_w = wb_cyc_in && wb_stb_in;
    wr_w = req_w && wb_we_in && ack_ff;
    wmask_w = sel_mask(wb_sel_in);
    nxt_ack = req_w && !ack_ff;
    nxt_rdat = rdat_ff;
    if (req_w && !ack_ff) begin
      unique case (wb_adr_in)
        ADDR_CTRL: nxt_rdat = {31'h0000_0000, serial_ff};
        ADDR_SWITCH_ENABLE_BITS: nxt_rdat = {28'h000_0000, switch_enable_bits_ff};
        ADDR_STATUS: nxt_rdat = status_w;
        ADDR_INT_STAT: nxt_rdat = {29'h0000_0000, int_stat_ff};
        ADDR_INT_MASK: nxt_rdat = {29'h0000_0000, int_mask_ff};
        default: nxt_rdat = 32'h0000_0000; // unmapped reads zero, writes dropped
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  assign wb_ack_out = ack_ff;
  assign wb_dat_out = rdat_ff;

  // ****************************************
  // status view
  // ****************************************
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[STAT_LOAD_LSB +: NUM_CH] = on_w;
    status_w[STAT_PRESENT_BIT] = present_w;
    status_w[STAT_LATCHED_BIT] = latched_w;
    status_w[STAT_COMM_LAT_BIT] = comm_lat_w;
    status_w[STAT_LOGIC_OK_BIT] = logic_supply_ok_in;
    status_w[STAT_SWITCH_OK_BIT] = switch_supply_ok_in;
    status_w[STAT_FLT_PIN_BIT] = fault_indicator_n_in;
    status_w[STAT_IND_PIN_LSB +: NUM_CH] = channel_status_indicator_n_in;
  end

  // ****************************************
  // control registers
  // ****************************************
  // writes land on the edge where the master sees ack
  // merged words are held in nets: a select straight on a call result is not legal
  always_comb begin
    wm_ctrl_w = merge({31'h0000_0000, serial_ff}, wb_dat_in, wmask_w);
    wm_switch_enable_bits_w = merge({28'h000_0000, switch_enable_bits_ff}, wb_dat_in, wmask_w);
    wm_int_mask_w = merge({29'h0000_0000, int_mask_ff}, wb_dat_in, wmask_w);
    nxt_serial = serial_ff;
    nxt_switch_enable_bits = switch_enable_bits_ff;
    nxt_int_mask = int_mask_ff;
    if (wr_w && wb_adr_in == ADDR_CTRL) begin
      nxt_serial = wm_ctrl_w[CTRL_SERIAL_BIT];
    end
    if (wr_w && wb_adr_in == ADDR_SWITCH_ENABLE_BITS) begin
      nxt_switch_enable_bits = wm_switch_enable_bits_w[NUM_CH-1:0];
    end
    if (wr_w && wb_adr_in == ADDR_INT_MASK) begin
      nxt_int_mask = wm_int_mask_w[INT_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      serial_ff <= CTRL_RESET[CTRL_SERIAL_BIT];
      switch_enable_bits_ff <= SWITCH_ENABLE_BITS_RESET;
      int_mask_ff <= INT_RESET;
    end else begin
      serial_ff <= nxt_serial;
      switch_enable_bits_ff <= nxt_switch_enable_bits;
      int_mask_ff <= nxt_int_mask;
    end
  end

  // ****************************************
  // interrupt
  // ****************************************
  // a new event wins over a write-one clear in the same cycle
  always_comb begin
    nxt_pres_d = present_w;
    nxt_latched_d = latched_w;
    event_w = {INT_WIDTH{1'b0}};
    event_w[INT_FAULT_RISE_BIT] = present_w && !pres_d_ff;
    event_w[INT_LATCH_FREE_BIT] = !latched_w && latched_d_ff;
    event_w[INT_OT_BLOCK_BIT] = |ot_block_w;
    nxt_int_stat = int_stat_ff;
    if (wr_w && wb_adr_in == ADDR_INT_STAT) begin
      nxt_int_stat = int_stat_ff & ~(wb_dat_in[INT_WIDTH-1:0] & wmask_w[INT_WIDTH-1:0]);
    end
    nxt_int_stat = nxt_int_stat | event_w;
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      int_stat_ff <= INT_RESET;
      pres_d_ff <= 1'b0;
      latched_d_ff <= 1'b0;
    end else begin
      int_stat_ff <= nxt_int_stat;
      pres_d_ff <= nxt_pres_d;
      latched_d_ff <= nxt_latched_d;
    end
  end

  assign irq_out = |(int_stat_ff & int_mask_ff);

  // ****************************************
  // checks
  // ****************************************
  a_logic_down_off: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !logic_supply_ok_in |=> (load_output_out == '0) && (channel_status_indicator_n_oe == '0))
    else $error("outputs active without logic supply");

  a_switch_down_flt: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (logic_supply_ok_in && !switch_supply_ok_in) |=> fault_indicator_n_oe
    && (load_output_out == '0))
    else $error("switch supply loss not reported as fault");

  a_latch_release: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (!present_w && fault_clear_input_in) |=> !fault_indicator_n_oe)
    else $error("fault indicator stuck after clear");

  a_ot_keeps_on: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (load_output_out[0] && chan_req_w[0] && !block_w) |=> load_output_out[0])
    else $error("running channel shut down by constraint fault");

  a_ov_normal: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (overvoltage_fault_in && !block_w && chan_req_w[1] && !overtemp_fault_in[1])
    |=> load_output_out[1] && fault_indicator_n_oe)
    else $error("over-voltage disturbed switching");

  a_comm_block: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (comm_lat_w && !load_output_out[2]) |=> !load_output_out[2])
    else $error("channel started with communication error remembered");

  a_status_pins: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (channel_status_indicator_n_oe == load_output_out) && !fault_indicator_n_out)
    else $error("indicator drive does not match load state");

  a_clean_follow: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (!block_w && !overtemp_fault_in[3] && !load_output_out[3]) ##1
    (!block_w && !overtemp_fault_in[3]) |-> load_output_out[3] == $past(chan_req_w[3]))
    else $error("channel does not follow enable and gate");

  a_latched_follow: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (latched_w && !present_w && !fault_clear_input_in && !block_w && chan_req_w[0]
    && !overtemp_fault_in[0]) |=> load_output_out[0] && fault_indicator_n_oe)
    else $error("remembered fault wrongly gates outputs");

  a_serial_source: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (serial_ff && switch_enable_bits_ff[0] && output_gate_in && !block_w && !overtemp_fault_in[0])
    |=> load_output_out[0])
    else $error("serial enable bit zero ignored");

  a_ack_single: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    wb_ack_out |=> !wb_ack_out)
    else $error("ack held for more than one cycle");
endmodule : iswfl_top
`default_nettype wire

// ==== bench/iswfl_host.sv ====
// host controller model: drives the channel, gate and clear pins and pulls up the indicators
`timescale 1ns/100ps
`default_nettype none
module iswfl_host
  import iswfl_pkg::*;
(
  input wire logic clk_sys_in, // system clock
  input wire logic rst_b_in, // async reset, active low
  input wire logic [NUM_CH-1:0] ch_cmd_in, // wanted channel levels
  input wire logic gate_cmd_in, // wanted gate level
  input wire logic clr_cmd_in, // wanted clear level
  input wire logic [NUM_CH-1:0] ind_oe_in, // status pins pulled low
  input wire logic flt_oe_in, // fault pin pulled low
  output logic [NUM_CH-1:0] channel_input_out, // channel pins
  output logic output_gate_out, // gate pin
  output logic fault_clear_input_out, // clear pin
  output logic [NUM_CH-1:0] ind_level_out, // status wire level
  output logic flt_level_out // fault wire level
);
  // pins always held at a defined level, low in reset, never left floating
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      channel_input_out <= '0;
      output_gate_out <= 1'b0;
      fault_clear_input_out <= 1'b0;
    end else begin
      channel_input_out <= ch_cmd_in;
      output_gate_out <= gate_cmd_in;
      fault_clear_input_out <= clr_cmd_in;
    end
  end

  // board pull-ups: a released open-drain pin reads high, never the last driven value
  assign ind_level_out = ~ind_oe_in;
  assign flt_level_out = ~flt_oe_in;
endmodule : iswfl_host
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench of the switch fault latch block with a host pin model
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import iswfl_pkg::*;
  localparam logic [4:0] OK = 5'h18; // both supplies up, no fault
  logic clk_sys_in, rst_b_in, wb_cyc, wb_stb, wb_we, wb_ack, irq;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat, wb_rdat, rd;
  logic [NUM_CH-1:0] ch_cmd, ch_pin, ot, loads, ind_oe, ind_out, ind_lvl;
  logic gate_cmd, clr_cmd, gate_pin, clr_pin, lok, sok, ov, ce, sd, flt_oe, flt_out, flt_lvl;
  int miscompares, samples_checked, cycles;

  iswfl_top u_iswfl_top (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc),
    .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel),
    .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack), .irq_out(irq),
    .channel_input_in(ch_pin), .output_gate_in(gate_pin), .fault_clear_input_in(clr_pin),
    .logic_supply_ok_in(lok), .switch_supply_ok_in(sok), .overtemp_fault_in(ot),
    .overvoltage_fault_in(ov), .comm_error_fault_in(ce), .shutdown_fault_in(sd),
    .load_output_out(loads), .channel_status_indicator_n_in(ind_lvl),
    .channel_status_indicator_n_out(ind_out), .channel_status_indicator_n_oe(ind_oe),
    .fault_indicator_n_in(flt_lvl), .fault_indicator_n_out(flt_out),
    .fault_indicator_n_oe(flt_oe));

  iswfl_host u_iswfl_host (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .ch_cmd_in(ch_cmd),
    .gate_cmd_in(gate_cmd), .clr_cmd_in(clr_cmd), .ind_oe_in(ind_oe), .flt_oe_in(flt_oe),
    .channel_input_out(ch_pin), .output_gate_out(gate_pin), .fault_clear_input_out(clr_pin),
    .ind_level_out(ind_lvl), .flt_level_out(flt_lvl));

  // ****************************************
  // clock, timeout and shared tasks
  // ****************************************
  // 125 MHz system clock
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  // a hang is cut short well above the few hundred cycles the run needs
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one classic cycle; the request stands until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= d;
    wb_sel <= 4'hf;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (wb_ack !== 1'b1 && n < 40);
    if (wb_ack !== 1'b1) begin
      miscompares++;
      close_out();
    end
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb_xfer

  // host pins and fault sources change on an edge, then outputs settle
  task automatic pins(input logic [3:0] c, input logic g, input logic k, input logic [3:0] t,
                      input logic [4:0] s);
    @(posedge clk_sys_in);
    ch_cmd <= c;
    gate_cmd <= g;
    clr_cmd <= k;
    ot <= t;
    {lok, sok, ov, ce, sd} <= s;
    repeat (5) @(posedge clk_sys_in);
    #1;
  endtask : pins

  task automatic outs(input logic [3:0] l, input logic f);
    check("loads", 32'(loads), 32'(l));
    check("status_oe", 32'(ind_oe), 32'(l));
    check("fault_oe", 32'(flt_oe), 32'(f));
  endtask : outs

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rst_b_in, wb_cyc, wb_stb, wb_we, gate_cmd, clr_cmd} = 6'h00;
    {wb_adr, wb_sel, wb_wdat, ch_cmd, ot} = '0;
    {lok, sok, ov, ce, sd} = OK;
    repeat (5) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    wb_xfer(1'b1, 8'h14, 32'hffff_ffff);
    for (int i = 0; i < 5; i++) begin
      wb_xfer(1'b0, 8'(i * 4 + ((i > 1) ? 4 : 0)), 32'h0000_0000);
      check("reset_reg", rd, 32'h0000_0000);
    end
    wb_xfer(1'b1, ADDR_INT_MASK, 32'h0000_0007);
    for (int i = 0; i < NUM_CH; i++) begin
      pins(4'(1 << i), 1'b1, 1'b0, 4'h0, OK);
      outs(4'(1 << i), 1'b0);
    end
    pins(4'hf, 1'b0, 1'b0, 4'h0, OK);
    outs(4'h0, 1'b0);
    pins(4'h5, 1'b1, 1'b0, 4'h0, OK);
    check("pin_drive", {ind_out, flt_out}, 32'h0000_0000);
    wb_xfer(1'b0, ADDR_STATUS, 32'h0000_0000);
    check("status", rd, 32'h0000_2b85);
    pins(4'h7, 1'b1, 1'b0, 4'h0, 5'h1c);
    outs(4'h7, 1'b1);
    pins(4'h5, 1'b1, 1'b1, 4'h0, OK);
    outs(4'h5, 1'b0);
    wb_xfer(1'b1, ADDR_INT_STAT, 32'h0000_0007);
    pins(4'h5, 1'b1, 1'b0, 4'h0, 5'h10);
    outs(4'h0, 1'b1);
    check("irq", 32'(irq), 32'h0000_0001);
    wb_xfer(1'b0, ADDR_INT_STAT, 32'h0000_0000);
    check("int_stat", rd, 32'h0000_0001);
    pins(4'h5, 1'b1, 1'b0, 4'h0, OK);
    outs(4'h5, 1'b1);
    pins(4'h5, 1'b0, 1'b0, 4'h0, OK);
    outs(4'h0, 1'b1);
    wb_xfer(1'b1, ADDR_INT_STAT, 32'h0000_0001);
    #1;
    check("irq_clr", 32'(irq), 32'h0000_0000);
    pins(4'h5, 1'b1, 1'b1, 4'h0, OK);
    outs(4'h5, 1'b0);
    wb_xfer(1'b0, ADDR_INT_STAT, 32'h0000_0000);
    check("int_free", rd, 32'h0000_0002);
    wb_xfer(1'b1, ADDR_INT_MASK, 32'h0000_0000);
    #1;
    check("irq_mask", 32'(irq), 32'h0000_0000);
    wb_xfer(1'b1, ADDR_INT_STAT, 32'h0000_0007);
    pins(4'h5, 1'b1, 1'b0, 4'h0, 5'h08);
    outs(4'h0, 1'b0);
    pins(4'h1, 1'b1, 1'b0, 4'h0, OK);
    outs(4'h1, 1'b0);
    pins(4'h1, 1'b1, 1'b0, 4'h3, OK);
    outs(4'h1, 1'b1);
    pins(4'h3, 1'b1, 1'b0, 4'h3, OK);
    outs(4'h1, 1'b1);
    wb_xfer(1'b0, ADDR_INT_STAT, 32'h0000_0000);
    check("int_ot", rd, 32'h0000_0005);
    pins(4'h3, 1'b1, 1'b1, 4'h0, OK);
    outs(4'h3, 1'b0);
    pins(4'h0, 1'b1, 1'b0, 4'h0, 5'h1a);
    pins(4'h7, 1'b1, 1'b0, 4'h0, OK);
    outs(4'h0, 1'b1);
    pins(4'h7, 1'b1, 1'b1, 4'h0, OK);
    outs(4'h7, 1'b0);
    pins(4'h3, 1'b1, 1'b0, 4'h0, 5'h19);
    outs(4'h0, 1'b1);
    pins(4'h0, 1'b1, 1'b1, 4'h0, OK);
    wb_xfer(1'b1, ADDR_CTRL, 32'h0000_0001);
    for (int i = 0; i < NUM_CH; i++) begin
      wb_xfer(1'b1, ADDR_SWITCH_ENABLE_BITS, 32'(1 << i));
      pins(4'h0, 1'b1, 1'b1, 4'h0, OK);
      outs(4'(1 << i), 1'b0);
    end
    wb_xfer(1'b0, ADDR_SWITCH_ENABLE_BITS, 32'h0000_0000);
    check("switch_enable_bits", rd, 32'h0000_0008);
    // reset again in mid-run: registers must return to pin mode and cleared enables
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    wb_xfer(1'b0, ADDR_SWITCH_ENABLE_BITS, 32'h0000_0000);
    check("switch_enable_bits_rst", rd, 32'(SWITCH_ENABLE_BITS_RESET));
    wb_xfer(1'b0, ADDR_CTRL, 32'h0000_0000);
    check("ctrl_rst", rd, CTRL_RESET);
    pins(4'hf, 1'b0, 1'b1, 4'h0, OK);
    outs(4'h0, 1'b0);
    close_out();
  end
endmodule : testbench
`default_nettype wire
